// file: cic_core.v
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "cic_defines.vh"
module cic_core (
    input  wire        clk_in,          // CPU clock, 40 MHz
    input  wire        srst_in,         // Synchronous reset, active high
    input  wire [1:0]  reg_addr_in,     // Register address
    input  wire [7:0]  reg_wdata_in,    // Register write data
    input  wire        reg_wr_in,       // Register write strobe
    input  wire        reg_rd_in,       // Register read strobe
    output reg  [7:0]  reg_rdata_out,   // Read data, cycle after strobe
    input  wire [4:0]  ext_pin_in,      // External lines ext_line_0..4 (NAND already applied)
    input  wire [4:0]  ext_gate_n_in,   // Low on any NANDed input holds the line low
    input  wire [13:0] periph_flag_in,  // Peripheral flags, level
    input  wire [13:0] periph_en_in,    // Peripheral enable bits
    input  wire [13:0] periph_clr_in,   // Clear-sequence pulse per source
    input  wire        trap_in,         // Software trap executed, pulse
    input  wire        insn_end_in,     // Current instruction finishes this cycle
    input  wire        ret_in,          // return_from_service executed, pulse
    input  wire        stack_done_in,   // Core finished one push or pop
    input  wire        ack_in,          // Core took the vector
    input  wire [2:0]  power_mode_in,   // Current low-power mode
    output reg         accept_out,      // Request accepted, vector valid
    output reg  [15:0] vector_out,      // Vector address
    output reg         push_out,        // Ask core to push one context item
    output reg         pop_out,         // Ask core to pop one context item
    output reg  [2:0]  stack_sel_out,   // 0 PC lo,1 PC hi,2 offset,3 accum,4 cond_code_reg
    output reg         gmask_out,       // Global mask flag
    output reg         wake_out         // Wake core from low-power mode
);
    localparam ST_IDLE  = `CIC_ST_IDLE;
    localparam ST_WAITI = `CIC_ST_WAITI;
    localparam ST_STACK = `CIC_ST_STACK;
    localparam ST_VEC   = `CIC_ST_VECTOR;
    localparam ST_RET   = `CIC_ST_RET;

    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [2:0]  cnt_r;
    reg         boot_r;
    reg         trap_r;
    reg  [9:0]  sense_r;
    reg  [4:0]  ext_prev_r;
    reg  [13:0] pend_r;
    reg  [13:0] pend_nxt;
    reg  [3:0]  sel_r;
    reg         sel_trap_r;
    reg  [13:0] ext_req;
    reg  [13:0] active;
    reg         any_act;
    reg  [3:0]  win;
    reg  [13:0] halt_cap;
    reg  [15:0] vec_nxt;
    wire [4:0]  line = ext_pin_in & ext_gate_n_in;              // [RULE_13]
    wire [13:0] ext_src_map = `CIC_EXT_SRC_MASK | (14'h1 << `CIC_SRC_EXT4);
    integer     i;
    integer     e_idx;
    integer     w_idx;
    wire [4:0]  ext_ev;

    // Map external line k to its source number
    function [3:0] ext_src;
        input integer k;
        begin
            ext_src = (k == 0) ? 4'h1 : (k == 1) ? 4'h2 : (k == 2) ? 4'h3 :
                      (k == 3) ? 4'h5 : 4'h6;
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_ext
            wire [1:0] s    = sense_r[2*g+1:2*g];
            wire       rise = line[g] & ~ext_prev_r[g];
            wire       fall = ~line[g] & ext_prev_r[g];
            wire       ev   = (s == `CIC_SENSE_FALLLOW) ? (fall | ~line[g]) :
                              (s == `CIC_SENSE_RISE)    ? rise :
                              (s == `CIC_SENSE_FALL)    ? fall : (rise | fall);  // [RULE_21]
            assign ext_ev[g] = ev;
        end
    endgenerate

    // One process owns every request bit, so no bit has two drivers
    always @* begin
        ext_req = 14'h0;
        for (e_idx = 0; e_idx < 5; e_idx = e_idx + 1) begin
            ext_req[ext_src(e_idx)] = ext_ev[e_idx];            // [RULE_11]
        end
    end

    // An external event wins over the acknowledge clear; a peripheral clear pulse and a sensitivity write clear win over a set
    always @* begin
        pend_nxt = pend_r;
        for (i = 0; i < `CIC_NSRC; i = i + 1) begin
            if (ext_src_map[i]) begin
                if (state_r == ST_VEC && ack_in && !sel_trap_r && sel_r == i[3:0]) begin
                    pend_nxt[i] = 1'b0;                         // [RULE_12]
                end
            end else if (periph_clr_in[i] || !periph_flag_in[i]) begin
                pend_nxt[i] = 1'b0;                             // [RULE_16]
            end
            if (ext_req[i] || (!ext_src_map[i] && periph_flag_in[i] && !periph_clr_in[i])) begin
                pend_nxt[i] = 1'b1;                             // [RULE_14]
            end
        end
        if (reg_wr_in && gmask_out && reg_addr_in == `CIC_ADDR_SENSE1) begin
            if (reg_wdata_in[1:0] != sense_r[1:0]) pend_nxt[1] = 1'b0;  // [RULE_22]
            if (reg_wdata_in[3:2] != sense_r[3:2]) pend_nxt[2] = 1'b0;
            if (reg_wdata_in[5:4] != sense_r[5:4]) pend_nxt[3] = 1'b0;
        end
        if (reg_wr_in && gmask_out && reg_addr_in == `CIC_ADDR_SENSE2) begin
            if (reg_wdata_in[1:0] != sense_r[7:6]) pend_nxt[5] = 1'b0;  // [RULE_22]
            if (reg_wdata_in[3:2] != sense_r[9:8]) pend_nxt[6] = 1'b0;
        end
        pend_nxt = pend_nxt & ~`CIC_UNUSED_MASK;                // [RULE_17]
    end

    // Active requests and lowest-number winner
    always @* begin
        active = pend_r & (ext_src_map | periph_en_in) & ~`CIC_UNUSED_MASK;  // [RULE_14]
        any_act = |active;
        win = 4'h0;
        for (w_idx = `CIC_NSRC - 1; w_idx >= 0; w_idx = w_idx - 1) begin
            if (active[w_idx]) win = w_idx[3:0];                // [RULE_08]
        end
    end

    // Halt-capable sources per mode
    always @* begin
        halt_cap = 14'h0;
        case (power_mode_in)
            `CIC_MODE_HALT: halt_cap = `CIC_EXT_SRC_MASK;       // [RULE_09]
            `CIC_MODE_AHALT: begin
                halt_cap = `CIC_EXT_SRC_MASK;
                halt_cap[`CIC_SRC_EXT4]      = 1'b1;            // [RULE_19]
                halt_cap[`CIC_SRC_RELOAD_OV] = 1'b1;            // [RULE_18]
                halt_cap[`CIC_SRC_TICK]      = 1'b1;
            end
            `CIC_MODE_HALTWK: begin
                halt_cap = `CIC_EXT_SRC_MASK;
                halt_cap[`CIC_SRC_AUTOWK] = 1'b1;               // [RULE_19]
            end
            default: halt_cap = 14'h3fff;                       // [RULE_09]
        endcase
        halt_cap[`CIC_SRC_SUPPLY] = (power_mode_in == `CIC_MODE_WAIT);  // [RULE_18]
    end

    always @* begin
        if (boot_r) begin
            vec_nxt = `CIC_VEC_RESET;
        end else if (sel_trap_r) begin
            vec_nxt = `CIC_VEC_TRAP;                            // [RULE_10]
        end else begin
            vec_nxt = `CIC_VEC_SRC0 - {11'h0, sel_r, 1'b0};     // [RULE_17]
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (boot_r) state_nxt = ST_VEC;                 // [RULE_08]
                else if (trap_r || (any_act && !gmask_out)) state_nxt = ST_WAITI;  // [RULE_01]
                else if (ret_in) state_nxt = ST_RET;
            end
            ST_WAITI:  if (insn_end_in) state_nxt = ST_STACK;   // [RULE_03]
            ST_STACK:  if (stack_done_in && cnt_r == `CIC_NSTACK - 3'h1) state_nxt = ST_VEC;
            ST_VEC:    if (ack_in) state_nxt = ST_IDLE;         // [RULE_24]
            ST_RET:    if (stack_done_in && cnt_r == `CIC_NSTACK - 3'h1) state_nxt = ST_IDLE;
            default:   state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge clk_in) begin
        if (srst_in) begin
            state_r       <= ST_IDLE;
            cnt_r         <= 3'h0;
            boot_r        <= 1'b1;
            trap_r        <= 1'b0;
            sense_r       <= 10'h0;
            ext_prev_r    <= 5'h1f;
            pend_r        <= 14'h0;
            sel_r         <= 4'h0;
            sel_trap_r    <= 1'b0;
            gmask_out     <= 1'b1;                              // [RULE_02]
            accept_out    <= 1'b0;
            vector_out    <= 16'h0;
            push_out      <= 1'b0;
            pop_out       <= 1'b0;
            stack_sel_out <= 3'h0;
            wake_out      <= 1'b0;
            reg_rdata_out <= 8'h0;
        end else begin
            state_r    <= state_nxt;
            ext_prev_r <= line;
            pend_r     <= pend_nxt;
            // A trap stays latched until it is the one taken; a new trap wins over the clear
            trap_r     <= trap_in |
                          (trap_r & ~(state_r == ST_WAITI && insn_end_in && sel_trap_r));
            if (state_r == ST_IDLE && state_nxt == ST_WAITI) begin
                sel_trap_r <= trap_r | trap_in;                 // [RULE_10]
                sel_r      <= win;
            end
            // Item index follows the counter, holding between done pulses
            if (state_nxt == ST_STACK || state_nxt == ST_RET) begin
                if (state_r != state_nxt) begin
                    cnt_r         <= 3'h0;
                    stack_sel_out <= 3'h0;
                end else if (stack_done_in) begin
                    cnt_r         <= cnt_r + 3'h1;
                    stack_sel_out <= cnt_r + 3'h1;              // [RULE_04]
                end
            end else begin
                stack_sel_out <= 3'h0;
            end
            push_out      <= (state_nxt == ST_STACK);           // [RULE_04]
            pop_out       <= (state_nxt == ST_RET);             // [RULE_07]
            if (state_r == ST_STACK && state_nxt == ST_VEC) begin
                gmask_out <= 1'b1;                              // [RULE_05]
            end
            if (state_r == ST_RET && state_nxt == ST_IDLE) begin
                gmask_out <= 1'b0;                              // [RULE_07]
            end
            if (state_nxt == ST_VEC) begin
                accept_out <= ~(state_r == ST_VEC && ack_in);
                vector_out <= vec_nxt;                          // [RULE_06]
            end else begin
                accept_out <= 1'b0;
            end
            if (state_r == ST_VEC && ack_in) boot_r <= 1'b0;
            wake_out <= (power_mode_in != `CIC_MODE_RUN) && (|(active & halt_cap) || trap_r);
            if (reg_wr_in && gmask_out) begin                   // [RULE_23]
                if (reg_addr_in == `CIC_ADDR_SENSE1) sense_r[5:0] <= reg_wdata_in[5:0];
                if (reg_addr_in == `CIC_ADDR_SENSE2) sense_r[9:6] <= reg_wdata_in[3:0];
            end
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `CIC_ADDR_SENSE1: reg_rdata_out <= {2'h0, sense_r[5:0]};
                    `CIC_ADDR_SENSE2: reg_rdata_out <= {4'h0, sense_r[9:6]};
                    `CIC_ADDR_PEND:   reg_rdata_out <= pend_r[7:0];
                    default:          reg_rdata_out <= {1'b0, pend_r[13:8], gmask_out};
                endcase
            end else begin
                reg_rdata_out <= 8'h0;
            end
        end
    end
endmodule // cic_core

// file: cic_defines.vh
// What this block does
// (RULE_01) Maskable requests are serviced only while the global mask is clear.
// (RULE_02) After reset the global mask is set and every interrupt disabled.
// (RULE_03) An accepted request waits for the current instruction to finish.
// (RULE_04) Service entry pushes program counter, offset, accumulator and condition codes.
// (RULE_05) Service entry sets the global mask.
// (RULE_06) After stacking, the program counter loads from the source's two-byte vector.
// (RULE_07) Return from service restores registers, clears the mask and resumes.
// (RULE_08) Fixed priority: reset, trap, then sources 0 to 13 ascending.
// (RULE_09) Any interrupt ends wait; only halt-capable sources end halt.
// (RULE_10) The trap always enters service at FFFC, regardless of the mask.
// (RULE_11) External line vectors are taken when event occurred and mask clear.
// (RULE_12) Edge events are latched and cleared on entry to their service.
// (RULE_13) A low on any NANDed input blocks that external line's request; the code forces the line low, a request under sensitivity 00, 10 or 11.
// (RULE_14) Peripheral flags request only when enabled and unmasked, else stay pending.
// (RULE_15) Software clears a peripheral request by writing 0 or a clear sequence.
// (RULE_16) A peripheral clear sequence discards the source's pending latch.
// (RULE_17) Vectors: reset FFFE, source 0 FFFA stepping down by two; 4,12,13 unused.
// (RULE_18) Reload overflow and timebase tick end active-halt only; others never halt.
// (RULE_19) Auto-wakeup ends wakeup-from-halt only; line 4 ends wait and active-halt.
// (RULE_20) Software should program line 4 sensitivity to 01.
// (RULE_21) Sensitivity 00 fall plus low, 01 rise, 10 fall, 11 both edges.
// (RULE_22) Writing a new sensitivity clears that line's pending request.
// (RULE_23) Sensitivity writes are accepted only while the global mask is set.
// (RULE_24) Vector is presented with the accept strobe and held until acknowledged.
`ifndef CIC_DEFINES_VH
`define CIC_DEFINES_VH
`define CIC_NSRC          14
`define CIC_VEC_RESET     16'hfffe
`define CIC_VEC_TRAP      16'hfffc
`define CIC_VEC_SRC0      16'hfffa
`define CIC_UNUSED_MASK   14'h3010
`define CIC_SRC_AUTOWK    0
`define CIC_SRC_EXT4      6
`define CIC_SRC_SUPPLY    7
`define CIC_SRC_RELOAD_OV 9
`define CIC_SRC_TICK      11
`define CIC_EXT_SRC_MASK  14'h002e
`define CIC_ADDR_SENSE1   2'h0
`define CIC_ADDR_SENSE2   2'h1
`define CIC_ADDR_PEND     2'h2
`define CIC_ADDR_STATE    2'h3
`define CIC_SENSE_FALLLOW 2'h0
`define CIC_SENSE_RISE    2'h1
`define CIC_SENSE_FALL    2'h2
`define CIC_SENSE_BOTH    2'h3
`define CIC_MODE_RUN      3'h0
`define CIC_MODE_WAIT     3'h1
`define CIC_MODE_HALT     3'h2
`define CIC_MODE_AHALT    3'h3
`define CIC_MODE_HALTWK   3'h4
`define CIC_ST_IDLE       3'h0
`define CIC_ST_WAITI      3'h1
`define CIC_ST_STACK      3'h2
`define CIC_ST_VECTOR     3'h3
`define CIC_ST_RET        3'h4
`define CIC_NSTACK        3'h5
`endif

// file: cic_core_monitor.sv
`timescale 1ns/1ps
module cic_core_monitor (
    input wire        clk_in,        // clock
    input wire        srst_in,       // reset
    input wire        trap_in,       // trap
    input wire        insn_end_in,   // insn end
    input wire        ret_in,        // return
    input wire        ack_in,        // vector taken
    input wire        stack_done_in, // item done
    input wire        accept_out,    // accepted
    input wire [15:0] vector_out,    // vector
    input wire        push_out,      // push
    input wire        pop_out,       // pop
    input wire [2:0]  stack_sel_out, // item
    input wire        gmask_out      // mask
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    property p_rst; $fell(srst_in) |-> gmask_out && !push_out && !pop_out; endproperty
    a_rst: assert property (p_rst) else $error("mask clear after reset");
    property p_hold; accept_out && !ack_in |=> accept_out && $stable(vector_out); endproperty
    a_hold: assert property (p_hold) else $error("vector dropped early");
    property p_map; accept_out |-> vector_out[15:5] == 11'h7ff && !vector_out[0]
        && vector_out != 16'hfff2 && vector_out[15:2] != 14'h3ff8; endproperty
    a_map: assert property (p_map) else $error("vector off map");
    property p_first; $rose(push_out) |-> stack_sel_out == 3'h0; endproperty
    a_first: assert property (p_first) else $error("stacking starts wrong");
    property p_item; (push_out || pop_out) && stack_sel_out != 3'h4 |=>
        stack_sel_out == $past(stack_sel_out) + {2'h0, $past(stack_done_in)}; endproperty
    a_item: assert property (p_item) else $error("stack item out of step");
    property p_ins; $rose(push_out) |-> $past(insn_end_in) || $past(insn_end_in, 2); endproperty
    a_ins: assert property (p_ins) else $error("stacked mid instruction");
    property p_mask; $fell(accept_out) |-> gmask_out; endproperty
    a_mask: assert property (p_mask) else $error("mask clear in service");
    property p_pop; ret_in |-> ##[1:4] pop_out; endproperty
    a_pop: assert property (p_pop) else $error("no unstack");
    property p_unm; ret_in |-> ##[1:200] !gmask_out; endproperty
    a_unm: assert property (p_unm) else $error("mask kept after return");
    property p_trap; trap_in |-> ##[1:200] accept_out && vector_out == 16'hfffc; endproperty
    a_trap: assert property (p_trap) else $error("trap not entered");
    property p_excl; !(push_out && pop_out); endproperty
    a_excl: assert property (p_excl) else $error("push with pop");
endmodule // cic_core_monitor
bind cic_core cic_core_monitor cic_core_monitor_i (.clk_in(clk_in), .srst_in(srst_in),
    .trap_in(trap_in), .insn_end_in(insn_end_in), .ret_in(ret_in), .ack_in(ack_in),
    .stack_done_in(stack_done_in),
    .accept_out(accept_out), .vector_out(vector_out), .push_out(push_out),
    .pop_out(pop_out), .stack_sel_out(stack_sel_out), .gmask_out(gmask_out));

// file: cic_core_partner.sv
`timescale 1ns/1ps
module cic_core_partner (
    input  wire clk_in,         // clock
    input  wire srst_in,        // reset
    input  wire push_in,        // push asked
    input  wire pop_in,         // pop asked
    input  wire accept_in,      // vector valid
    input  wire slow_in,        // stretch answers
    output reg  insn_end_out,   // insn boundary
    output reg  stack_done_out, // item done
    output reg  ack_out         // vector taken
);
    // Done pulses never come back to back, so an item is never counted twice
    always @(posedge clk_in) begin
        insn_end_out <= !srst_in && ($urandom % 3 == 0);
        stack_done_out <= !srst_in && (push_in || pop_in) && !stack_done_out
            && (!slow_in || $urandom % 2);
        ack_out <= !srst_in && accept_in && !ack_out && (!slow_in || $urandom % 2);
    end
endmodule // cic_core_partner

// file: cic_core_tb_top.sv
`timescale 1ns/1ps
module cic_core_tb_top;
    reg         clk_in = 1'b0;
    reg         srst_in = 1'b1;
    reg  [1:0]  addr = 2'h0;
    reg  [7:0]  wdata = 8'h00;
    reg         wr = 1'b0, rd = 1'b0, trap = 1'b0, ret = 1'b0, slow = 1'b0;
    reg  [4:0]  pin = 5'h1f, gate_n = 5'h1f;
    reg  [13:0] flag = 14'h0, en = 14'h0, clr = 14'h0;
    reg  [2:0]  mode = 3'h0;
    wire [7:0]  rdata;
    wire [15:0] vec;
    wire [2:0]  sel;
    wire        accept, push, pop, gmask, wake, insn_end, sdone, ack;
    integer     error_cnt = 0, n_tests = 0, i, c, k, r, s, m;
    always #12.5 clk_in = ~clk_in;
    cic_core cic_core_i (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .ext_pin_in(pin), .ext_gate_n_in(gate_n), .periph_flag_in(flag), .periph_en_in(en),
        .periph_clr_in(clr), .trap_in(trap), .insn_end_in(insn_end), .ret_in(ret),
        .stack_done_in(sdone), .ack_in(ack), .power_mode_in(mode), .accept_out(accept),
        .vector_out(vec), .push_out(push), .pop_out(pop), .stack_sel_out(sel),
        .gmask_out(gmask), .wake_out(wake));
    cic_core_partner cic_core_partner_i (.clk_in(clk_in), .srst_in(srst_in), .push_in(push),
        .pop_in(pop), .accept_in(accept), .slow_in(slow), .insn_end_out(insn_end),
        .stack_done_out(sdone), .ack_out(ack));
    task chk(input [16:0] got, input [16:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("FAIL %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task service(input [15:0] v);
        begin
            for (i = 0; i < 400 && accept !== 1'b1; i = i + 1) begin
                @(posedge clk_in);
                #1;
            end
            chk({accept, vec}, {1'b1, v});
            for (i = 0; i < 50 && accept === 1'b1; i = i + 1) @(posedge clk_in);
        end
    endtask
    task pulse(input integer t);
        begin
            @(posedge clk_in) {trap, ret} <= (t == 1) ? 2'h2 : 2'h1;
            @(posedge clk_in) {trap, ret} <= 2'h0;
        end
    endtask
    task wr_reg(input [1:0] a, input [7:0] d);
        begin
            @(posedge clk_in) {addr, wdata, wr} <= {a, d, 1'b1};
            @(posedge clk_in) wr <= 1'b0;
        end
    endtask
    task rd_reg(input [1:0] a, input [7:0] exp);
        begin
            @(posedge clk_in) {addr, rd} <= {a, 1'b1};
            @(posedge clk_in) rd <= 1'b0;
            #1;
            chk(rdata, exp);
        end
    endtask
    // Looks every cycle, since a stray accept stands only until the core acks it
    task noacc(input integer n);
        reg seen;
        begin
            seen = 1'b0;
            repeat (n) begin
                @(posedge clk_in);
                #1;
                seen = seen | (accept !== 1'b0);
            end
            chk(seen, 1'b0);
        end
    endtask
    function [0:0] wexp(input integer md, input integer sr);
        case (md)
            1: wexp = 1'b1;
            3: wexp = (sr == 9 || sr == 11);
            4: wexp = (sr == 0);
            default: wexp = 1'b0;
        endcase
    endfunction
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", n_tests, error_cnt);
            if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        r = $urandom(32'hf5e6949f);
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in) #1;
        chk(gmask, 1'b1);
        service(16'hfffe);
        pulse(1);
        service(16'hfffc);
        wr_reg(2'h1, 8'h04);
        rd_reg(2'h1, 8'h04);
        $display("reset and trap tests done");
        @(posedge clk_in) {flag[9], en[9]} <= 2'h3;
        noacc(20);
        pulse(0);
        service(16'hffe8);
        @(posedge clk_in) flag <= 14'h0480;
        en <= 14'h0480;
        pulse(0);
        service(16'hffec);
        @(posedge clk_in) flag[7] <= 1'b0;
        pulse(0);
        service(16'hffe6);
        @(posedge clk_in) flag <= 14'h0100;
        en <= 14'h0;
        @(posedge clk_in) {flag[8], clr[8]} <= 2'h1;
        @(posedge clk_in) {en[8], clr[8]} <= 2'h2;
        pulse(0);
        noacc(60);
        $display("peripheral tests done");
        pulse(1);
        service(16'hfffc);
        for (c = 0; c < 4; c = c + 1) begin
            @(posedge clk_in) pin[0] <= (c == 0 || c == 2);
            wr_reg(2'h0, c[7:0]);
            rd_reg(2'h0, c[7:0]);
            pulse(0);
            noacc(60);
            @(posedge clk_in) begin
                pin[0]    <= ~pin[0];
                gate_n[0] <= (c != 1);
            end
            if (c == 1) begin
                noacc(20);
                @(posedge clk_in) gate_n[0] <= 1'b1;
            end
            service(16'hfff8);
        end
        pulse(0);
        noacc(60);
        wr_reg(2'h0, 8'h01);
        rd_reg(2'h0, 8'h03);
        $display("external line tests done");
        @(posedge clk_in) slow <= 1'b1;
        for (k = 0; k < 8; k = k + 1) begin
            r = $urandom % 6;
            s = (r == 0) ? 0 : r + 6;
            m = $urandom % 5;
            @(posedge clk_in);
            mode <= m[2:0];
            flag[s] <= 1'b1;
            en[s] <= 1'b1;
            repeat (4) @(posedge clk_in);
            #1;
            if (m != 0) chk(wake, wexp(m, s));
            @(posedge clk_in) mode <= 3'h0;
            service(16'hfffa - 2 * s);
            @(posedge clk_in) flag[s] <= 1'b0;
            en[s] <= 1'b0;
            pulse(0);
            repeat (200) @(posedge clk_in);
        end
        $display("random tests done");
        tally_and_finish;
    end
    // Whole run is a few thousand cycles; this bound only cuts a hang
    initial begin
        #(25 * 40000);
        error_cnt = error_cnt + 1;
        tally_and_finish;
    end
endmodule // cic_core_tb_top
